// *** verilog/tbt_top.sv ***
// Broadcast trigger enable, timer limits and the output pulse logic behind an APB slave.
// Functional notes
// R1 - Broadcast bits 15..12 gate the four ADC sample-trigger outputs.
// R2 - Broadcast bits 11..8 gate sync pulses to capture units 4..1.
// R3 - Broadcast bits 7..4 gate clock pulses to compare units 4..1.
// R4 - Broadcast bits 3..0 gate sync pulses to compare units 4..1.
// R5 - Broadcast register is used only by the control step with option 1111.
// R6 - While enabled and started, broadcast and limit registers ignore writes.
// R7 - Timer 0 limit holds 16 bits, used only by the wait-timer-0 step.
// R8 - Timer 1 limit holds 16 bits, used only by the wait-timer-1 step.
// R9 - Pulse mode outputs last width field plus one clock cycles.
// R10 - Toggle mode inverts outputs on each trigger step.
// R11 - All enabled broadcast outputs start in the same clock cycle.
// R12 - Broadcast and both limit registers reset to zero.
`timescale 1ns/1ps
`include "tbt_consts.svh"
module tbt_top #(
  parameter int NUM_OUT = 16
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Trigger outputs
  output logic [NUM_OUT-1:0] TRIG_OUT,
  output logic WAIT_DONE
);
  if (NUM_OUT != 16) begin : g_bad_num_out
    $error("tbt_top serves exactly 16 broadcast outputs");
  end

  logic [15:0] bcast_ff;
  logic [15:0] t0lim_ff;
  logic [15:0] t1lim_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] timer_ff;
  logic [15:0] wait_lim_ff;
  tbt_pkg::tbt_state_e state_ff;
  logic step_go;
  logic [1:0] step_kind;
  logic [3:0] step_opt;
  logic locked;
  logic wr_en;
  logic rd_en;
  logic bcast_fire;
  logic trig_fire;
  logic [NUM_OUT-1:0] fire_vec;
  logic [15:0] rd_mux;
  logic addr_ok;
  tbt_pkg::tbt_bcast_s bcast_view;

  assign locked = ctrl_ff[`TBT_CTRL_EN_BIT] & ctrl_ff[`TBT_CTRL_START_BIT];
  // Writes land on the edge where the master sees PREADY, never one edge before it.
  assign wr_en = PSEL & PENABLE & PWRITE & PREADY & CE;
  assign rd_en = PSEL & PENABLE & ~PWRITE & ~PREADY & CE;
  // Step issue is a write to the step port; a step is taken only while running.
  assign step_go = wr_en && PADDR == `TBT_OFF_STEP && locked && state_ff == tbt_pkg::ST_IDLE;
  assign step_kind = PWDATA[5:4];
  assign step_opt = PWDATA[3:0];
  assign bcast_view = tbt_pkg::tbt_bcast_s'(bcast_ff);

  // R5 option decode
  assign bcast_fire = step_go && step_kind == 2'(tbt_pkg::STEP_CONTROL)
                      && step_opt == `TBT_OPT_BROADCAST;
  assign trig_fire = step_go && step_kind == 2'(tbt_pkg::STEP_TRIGGER);

  // R1 R2 R3 R4 per-output gating
  assign fire_vec = bcast_fire ? {bcast_view.adc_trig, bcast_view.cap_sync,
                                  bcast_view.cmp_clk, bcast_view.cmp_sync}
                  : (trig_fire ? (16'h0001 << step_opt) : 16'h0000);

  // R11 common fire strobe, R9 R10 shaping
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      tbt_pulse u_pulse (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .ce(CE),
        .fire(fire_vec[gi]),
        .toggle_mode(ctrl_ff[`TBT_CTRL_TOGGLE_BIT]),
        .width(ctrl_ff[`TBT_CTRL_PWD_LSB +: 4]),
        .out(TRIG_OUT[gi])
      );
    end
  endgenerate

  // R12 reset values, R6 write lock
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      bcast_ff <= `TBT_RST_BCAST;
      t0lim_ff <= `TBT_RST_T0LIM;
      t1lim_ff <= `TBT_RST_T1LIM;
    end else if (wr_en && !locked) begin
      if (PADDR == `TBT_OFF_BCAST) bcast_ff <= PWDATA[15:0];
      if (PADDR == `TBT_OFF_T0LIM) t0lim_ff <= PWDATA[15:0];
      if (PADDR == `TBT_OFF_T1LIM) t1lim_ff <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_ff <= `TBT_RST_CTRL;
    end else if (wr_en && PADDR == `TBT_OFF_CTRL) begin
      ctrl_ff <= {8'h00, PWDATA[7:4], 1'b0, PWDATA[2:0]};
    end
  end

  // R7 R8 limits consulted only by the matching wait step
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= tbt_pkg::ST_IDLE;
      timer_ff <= 16'h0000;
      wait_lim_ff <= 16'h0000;
      WAIT_DONE <= 1'b0;
    end else if (CE) begin
      WAIT_DONE <= 1'b0;
      case (state_ff)
        tbt_pkg::ST_IDLE: begin
          if (step_go && step_kind == 2'(tbt_pkg::STEP_WAIT_T0)) begin
            wait_lim_ff <= t0lim_ff;
            timer_ff <= 16'h0000;
            state_ff <= tbt_pkg::ST_WAIT;
          end else if (step_go && step_kind == 2'(tbt_pkg::STEP_WAIT_T1)) begin
            wait_lim_ff <= t1lim_ff;
            timer_ff <= 16'h0000;
            state_ff <= tbt_pkg::ST_WAIT;
          end
        end
        tbt_pkg::ST_WAIT: begin
          if (!locked) begin
            state_ff <= tbt_pkg::ST_IDLE;
          end else if (timer_ff == wait_lim_ff) begin
            WAIT_DONE <= 1'b1;
            state_ff <= tbt_pkg::ST_IDLE;
          end else begin
            timer_ff <= timer_ff + 16'h0001;
          end
        end
        default: state_ff <= tbt_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 16'h0000;
    case (PADDR)
      `TBT_OFF_BCAST: rd_mux = bcast_ff;
      `TBT_OFF_T0LIM: rd_mux = t0lim_ff;
      `TBT_OFF_T1LIM: rd_mux = t1lim_ff;
      `TBT_OFF_CTRL: rd_mux = ctrl_ff;
      `TBT_OFF_STEP: rd_mux = 16'h0000;
      `TBT_OFF_STAT: rd_mux = {14'h0000, locked, state_ff == tbt_pkg::ST_WAIT};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answers one cycle into the access phase.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else if (CE) begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
      if (rd_en) PRDATA <= {16'h0000, rd_mux};
    end
  end

  // R6 write lock
  property p_lock_bcast;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (locked && PSEL && PENABLE && PWRITE) |=> $stable(bcast_ff);
  endproperty
  a_lock_bcast: assert property (p_lock_bcast) else $error("broadcast changed while locked"); // R6

  property p_lock_t0;
    @(posedge CLK_SYS) disable iff (!RSTN)
      locked |=> $stable(t0lim_ff);
  endproperty
  a_lock_t0: assert property (p_lock_t0) else $error("timer0 limit changed while locked"); // R6

  property p_lock_t1;
    @(posedge CLK_SYS) disable iff (!RSTN)
      locked |=> $stable(t1lim_ff);
  endproperty
  a_lock_t1: assert property (p_lock_t1) else $error("timer1 limit changed while locked"); // R6

  property p_bcast_out;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && !ctrl_ff[`TBT_CTRL_TOGGLE_BIT]) |=> ((TRIG_OUT & bcast_ff) == bcast_ff);
  endproperty
  a_bcast_out: assert property (p_bcast_out) else $error("enabled output not raised"); // R11

  property p_bcast_mask;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && !ctrl_ff[`TBT_CTRL_TOGGLE_BIT] && ($past(TRIG_OUT) == 16'h0000))
      |=> ((TRIG_OUT & ~bcast_ff) == 16'h0000);
  endproperty
  a_bcast_mask: assert property (p_bcast_mask) else $error("disabled output raised"); // R1

  property p_only_opt;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && step_go && step_kind == 2'(tbt_pkg::STEP_CONTROL) && step_opt != `TBT_OPT_BROADCAST)
      |=> ((TRIG_OUT & ~$past(TRIG_OUT)) == 16'h0000);
  endproperty
  a_only_opt: assert property (p_only_opt) else $error("broadcast on wrong option"); // R5

  property p_width0;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && bcast_ff[0] && ctrl_ff[7:4] == 4'h0 && !ctrl_ff[2])
      ##1 (CE && !fire_vec[0] && $stable(ctrl_ff)) |=> !TRIG_OUT[0];
  endproperty
  a_width0: assert property (p_width0) else $error("one-cycle pulse too long"); // R9

  property p_toggle;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && trig_fire && ctrl_ff[2]) |=> (TRIG_OUT[$past(step_opt)] != $past(TRIG_OUT[step_opt]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert"); // R10

  // R1 ADC group gating
  property p_adc_group;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && !ctrl_ff[`TBT_CTRL_TOGGLE_BIT]
       && TRIG_OUT[`TBT_BCAST_ADC_LSB +: 4] == 4'h0)
      |=> (TRIG_OUT[`TBT_BCAST_ADC_LSB +: 4] == bcast_ff[`TBT_BCAST_ADC_LSB +: 4]);
  endproperty
  a_adc_group: assert property (p_adc_group) else $error("ADC trigger group wrong"); // R1

  // R2 capture sync gating
  property p_cap_group;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && !ctrl_ff[`TBT_CTRL_TOGGLE_BIT]
       && TRIG_OUT[`TBT_BCAST_ICS_LSB +: 4] == 4'h0)
      |=> (TRIG_OUT[`TBT_BCAST_ICS_LSB +: 4] == bcast_ff[`TBT_BCAST_ICS_LSB +: 4]);
  endproperty
  a_cap_group: assert property (p_cap_group) else $error("capture sync group wrong"); // R2

  // R3 compare clock gating
  property p_cmp_clk_group;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && !ctrl_ff[`TBT_CTRL_TOGGLE_BIT]
       && TRIG_OUT[`TBT_BCAST_OCC_LSB +: 4] == 4'h0)
      |=> (TRIG_OUT[`TBT_BCAST_OCC_LSB +: 4] == bcast_ff[`TBT_BCAST_OCC_LSB +: 4]);
  endproperty
  a_cmp_clk_group: assert property (p_cmp_clk_group) else $error("compare clock group wrong"); // R3

  // R4 compare sync gating
  property p_cmp_sync_group;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && !ctrl_ff[`TBT_CTRL_TOGGLE_BIT]
       && TRIG_OUT[`TBT_BCAST_OCS_LSB +: 4] == 4'h0)
      |=> (TRIG_OUT[`TBT_BCAST_OCS_LSB +: 4] == bcast_ff[`TBT_BCAST_OCS_LSB +: 4]);
  endproperty
  a_cmp_sync_group: assert property (p_cmp_sync_group) else $error("compare sync group wrong"); // R4

  // R12 registers cleared
  property p_rst_regs;
    @(posedge CLK_SYS)
      !RSTN |=> (bcast_ff == `TBT_RST_BCAST && t0lim_ff == `TBT_RST_T0LIM
                 && t1lim_ff == `TBT_RST_T1LIM);
  endproperty
  a_rst_regs: assert property (p_rst_regs) else $error("register not cleared by reset"); // R12

  // R12 outputs quiet
  property p_rst_out;
    @(posedge CLK_SYS)
      !RSTN |=> (TRIG_OUT == 16'h0000 && !WAIT_DONE);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("output active after reset"); // R12

  // R7 timer 0 limit
  property p_wait_t0;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && step_go && step_kind == 2'(tbt_pkg::STEP_WAIT_T0)) |=> (wait_lim_ff == $past(t0lim_ff));
  endproperty
  a_wait_t0: assert property (p_wait_t0) else $error("wait step 0 took wrong limit"); // R7

  // R8 timer 1 limit
  property p_wait_t1;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && step_go && step_kind == 2'(tbt_pkg::STEP_WAIT_T1)) |=> (wait_lim_ff == $past(t1lim_ff));
  endproperty
  a_wait_t1: assert property (p_wait_t1) else $error("wait step 1 took wrong limit"); // R8

  // R10 broadcast toggle
  property p_toggle_bcast;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (CE && bcast_fire && ctrl_ff[`TBT_CTRL_TOGGLE_BIT])
      |=> ((TRIG_OUT ^ $past(TRIG_OUT)) == $past(bcast_ff));
  endproperty
  a_toggle_bcast: assert property (p_toggle_bcast) else $error("broadcast toggle wrong"); // R10

  // The status and bus strobes stand for exactly one cycle.
  property p_done_pulse;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (WAIT_DONE && CE) |=> !WAIT_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("wait done longer than one cycle");

  property p_ready_pulse;
    @(posedge CLK_SYS) disable iff (!RSTN)
      (PREADY && CE) |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  property p_slverr_ready;
    @(posedge CLK_SYS) disable iff (!RSTN)
      PSLVERR |-> PREADY;
  endproperty
  a_slverr_ready: assert property (p_slverr_ready) else $error("error response without ready");

  property p_rdata_hold;
    @(posedge CLK_SYS) disable iff (!RSTN)
      !rd_en |=> $stable(PRDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");
endmodule : tbt_top

// *** verilog/tbt_consts.svh ***
// Register offsets, field positions, reset values and the broadcast option code of the trigger broadcast block.
`ifndef TBT_CONSTS_SVH
`define TBT_CONSTS_SVH
`define TBT_OFF_BCAST 12'h000
`define TBT_OFF_T0LIM 12'h004
`define TBT_OFF_T1LIM 12'h008
`define TBT_OFF_CTRL 12'h00c
`define TBT_OFF_STEP 12'h010
`define TBT_OFF_STAT 12'h014
`define TBT_RST_BCAST 16'h0000
`define TBT_RST_T0LIM 16'h0000
`define TBT_RST_T1LIM 16'h0000
`define TBT_RST_CTRL 16'h0000
`define TBT_CTRL_EN_BIT 0
`define TBT_CTRL_START_BIT 1
`define TBT_CTRL_TOGGLE_BIT 2
`define TBT_CTRL_PWD_LSB 4
`define TBT_BCAST_ADC_LSB 12
`define TBT_BCAST_ICS_LSB 8
`define TBT_BCAST_OCC_LSB 4
`define TBT_BCAST_OCS_LSB 0
`define TBT_OPT_BROADCAST 4'hf
`endif

// *** verilog/tbt_pkg.sv ***
// Types shared by the trigger broadcast block.
package tbt_pkg;
  typedef enum logic [1:0] {
    STEP_CONTROL,
    STEP_TRIGGER,
    STEP_WAIT_T0,
    STEP_WAIT_T1
  } tbt_step_e;
  typedef struct packed {
    logic [3:0] adc_trig;
    logic [3:0] cap_sync;
    logic [3:0] cmp_clk;
    logic [3:0] cmp_sync;
  } tbt_bcast_s;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT
  } tbt_state_e;
endpackage : tbt_pkg

// *** verilog/tbt_pulse.sv ***
// One trigger output line: fixed-width pulse or toggle.
`timescale 1ns/1ps
module tbt_pulse (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic fire,
  input wire logic toggle_mode,
  input wire logic [3:0] width,
  // Output
  output logic out
);
  logic [3:0] cnt_ff;
  logic active_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out <= 1'b0;
      cnt_ff <= 4'h0;
      active_ff <= 1'b0;
    end else if (ce) begin
      if (fire && toggle_mode) begin
        out <= ~out;
        active_ff <= 1'b0;
      end else if (fire) begin
        out <= 1'b1;
        cnt_ff <= width;
        active_ff <= 1'b1;
      end else if (active_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (active_ff) begin
        out <= 1'b0;
        active_ff <= 1'b0;
      end
    end
  end
endmodule : tbt_pulse

// *** bench/tbt_periph.sv ***
// Peripheral side model that counts trigger pulses and measures their width.
`timescale 1ns/1ps
module tbt_periph (
  // Clock
  input wire logic clk,
  // Trigger lines from the block
  input wire logic [15:0] trig
);
  int rises [16] = '{default: 0};
  int width [16] = '{default: 0};
  int first [16] = '{default: 0};
  int cyc = 0;
  logic [15:0] prev = 16'h0;
  // A line counts as one event per rising edge, since the peripherals are edge triggered.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev <= trig;
    for (int i = 0; i < 16; i++) begin
      if (trig[i] === 1'h1 && prev[i] !== 1'h1) begin
        rises[i] <= rises[i] + 1;
        width[i] <= 1;
        first[i] <= cyc;
      end else if (trig[i] === 1'h1) begin
        width[i] <= width[i] + 1;
      end
    end
  end
endmodule : tbt_periph

// *** bench/tbt_top_tb.sv ***
// Self-checking bench for the trigger broadcast block.
`timescale 1ns/1ps
`include "tbt_consts.svh"
module tbt_top_tb;
  logic CLK_SYS = 1'h0;
  logic RSTN = 1'h0;
  logic CE = 1'h1;
  logic PSEL = 1'h0;
  logic PENABLE = 1'h0;
  logic PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [15:0] TRIG_OUT;
  logic WAIT_DONE;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int n_compared = 0;
  int base [16];
  int n0;
  int n1;
  tbt_top i_dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TRIG_OUT(TRIG_OUT), .WAIT_DONE(WAIT_DONE));
  tbt_periph i_per (.clk(CLK_SYS), .trig(TRIG_OUT));
  initial begin
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  task automatic end_sim();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk16(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk16
  task automatic chki(input string s, input int e, input int g);
    n_compared++;
    if (g != e) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", s, e, g);
    end
  endtask : chki
  // Values are read in the active region of the edge, before the slave's updates land.
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {16'h0, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLK_SYS);
  endtask : apb
  task automatic t_bcast();
    wr_pair(`TBT_OFF_BCAST, 16'ha5c3, `TBT_OFF_CTRL, 16'h0023);
    foreach (base[i]) base[i] = i_per.rises[i];
    apb(1'h1, `TBT_OFF_STEP, 16'h000f);
    repeat (20) @(posedge CLK_SYS);
    for (int i = 0; i < 16; i++) begin
      chki("rises", int'(16'ha5c3 >> i) & 1, i_per.rises[i] - base[i]);
      if (16'ha5c3 & (16'h1 << i)) begin
        chki("width", 3, i_per.width[i]);
        chki("start", i_per.first[0], i_per.first[i]);
      end
    end
    apb(1'h1, `TBT_OFF_STEP, 16'h0000);
    repeat (20) @(posedge CLK_SYS);
    chki("other step", base[0] + 1, i_per.rises[0]);
    wr_pair(`TBT_OFF_BCAST, 16'hffff, `TBT_OFF_T0LIM, 16'h1234);
    apb(1'h0, `TBT_OFF_BCAST, 16'h0);
    chk16("locked bcast", 16'ha5c3, rd[15:0]);
    apb(1'h0, `TBT_OFF_T0LIM, 16'h0);
    chk16("locked limit", 16'h0000, rd[15:0]);
  endtask : t_bcast
  task automatic wr_pair(input logic [11:0] a, input logic [15:0] d, input logic [11:0] b,
      input logic [15:0] e);
    apb(1'h1, a, d);
    apb(1'h1, b, e);
  endtask : wr_pair
  task automatic t_toggle();
    wr_pair(`TBT_OFF_CTRL, 16'h0007, `TBT_OFF_STEP, 16'h000f);
    repeat (4) @(posedge CLK_SYS);
    chk16("toggle on", 16'ha5c3, TRIG_OUT);
    apb(1'h1, `TBT_OFF_STEP, 16'h000f);
    repeat (4) @(posedge CLK_SYS);
    chk16("toggle off", 16'h0000, TRIG_OUT);
    apb(1'h1, `TBT_OFF_STEP, 16'h0013);
    repeat (4) @(posedge CLK_SYS);
    chk16("toggle step on", 16'h0008, TRIG_OUT);
    apb(1'h1, `TBT_OFF_STEP, 16'h0013);
    repeat (4) @(posedge CLK_SYS);
    chk16("toggle step off", 16'h0000, TRIG_OUT);
    wr_pair(`TBT_OFF_CTRL, 16'h0003, `TBT_OFF_STEP, 16'h000f);
    repeat (4) @(posedge CLK_SYS);
    chki("width min", 1, i_per.width[0]);
  endtask : t_toggle
  task automatic t_wait(input logic [15:0] s, output int n);
    apb(1'h1, `TBT_OFF_STEP, s);
    n = 0;
    while (WAIT_DONE !== 1'h1 && n < 100) begin
      @(posedge CLK_SYS);
      n++;
    end
  endtask : t_wait
  initial begin
    repeat (2) @(posedge CLK_SYS);
    RSTN <= 1'h1;
    @(posedge CLK_SYS);
    for (int a = 0; a < 3; a++) begin
      apb(1'h0, 12'(4 * a), 16'h0);
      chk16("reset value", 16'h0000, rd[15:0]);
    end
    t_bcast();
    t_toggle();
    apb(1'h1, `TBT_OFF_CTRL, 16'h0000);
    wr_pair(`TBT_OFF_T0LIM, 16'h0005, `TBT_OFF_T1LIM, 16'h0009);
    apb(1'h0, `TBT_OFF_T1LIM, 16'h0);
    chk16("limit hold", 16'h0009, rd[15:0]);
    apb(1'h1, `TBT_OFF_CTRL, 16'h0003);
    t_wait(16'h0020, n0);
    t_wait(16'h0030, n1);
    chki("wait spread", 4, n1 - n0);
    apb(1'h0, 12'h020, 16'h0);
    chk16("unmapped error", 16'h0001, {15'h0, er});
    end_sim();
  end
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule : tbt_top_tb
